// file: src/cpc_params.svh
// constants for the core program-counter, stack and interrupt control block
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH

// ============================================================================
// register indices (byte address is four times the index)
`define CPC_IDX_WINDOW     9'h000
`define CPC_IDX_PC_LOW     9'h002
`define CPC_IDX_PTR        9'h004
`define CPC_IDX_PC_HIGH    9'h00a
`define CPC_IDX_IRQ_CTRL   9'h00b
`define CPC_IDX_CMD        9'h100
`define CPC_IDX_CORE_STAT  9'h101

// ============================================================================
// interrupt control fields
`define CPC_GIE_BIT        7
`define CPC_EEPROM_DONE_IRQ_ENABLE_BIT       6
`define CPC_TIMER_OVERFLOW_IRQ_ENABLE_BIT       5
`define CPC_EXT_PIN_IRQ_ENABLE_BIT       4
`define CPC_PORT_CHANGE_IRQ_ENABLE_BIT       3
`define CPC_TIMER_OVERFLOW_FLAG_BIT       2
`define CPC_EXT_PIN_IRQ_FLAG_BIT       1
`define CPC_PORT_CHANGE_FLAG_BIT       0

// ============================================================================
// command and core status fields
`define CPC_CMD_OP_HI      14
`define CPC_CMD_OP_LO      12
`define CPC_CMD_TGT_HI     10
`define CPC_STAT_IRQ_BIT   16
`define CPC_STAT_EEF_BIT   17

// ============================================================================
// reset values and fixed addresses
`define CPC_IRQ_CTRL_RST   8'h00
`define CPC_PC_RST         13'h0000
`define CPC_PTR_RST        8'h00
`define CPC_PC_HIGH_RST    5'h00
`define CPC_IRQ_VECTOR     13'h0004

`endif

// file: src/cpc_pkg.sv
// types shared by the core program-counter, stack and interrupt control block
package cpc_pkg;

    typedef enum logic [2:0] {
        CPC_OP_NOP,
        CPC_OP_STEP,
        CPC_OP_GOTO,
        CPC_OP_CALL,
        CPC_OP_RETURN,
        CPC_OP_RETLIT,
        CPC_OP_RETIRQ,
        CPC_OP_IRQ_ACK
    } cpc_op_t;

    typedef enum logic [3:0] {
        CPC_SEL_NONE,
        CPC_SEL_WINDOW,
        CPC_SEL_PC_LOW,
        CPC_SEL_PTR,
        CPC_SEL_PC_HIGH,
        CPC_SEL_IRQ_CTRL,
        CPC_SEL_MEM,
        CPC_SEL_CMD,
        CPC_SEL_CORE_STAT
    } cpc_sel_t;

endpackage : cpc_pkg

// file: src/cpc_core.sv
// core program counter, return stack, indirect access and interrupt control
`include "cpc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module cpc_core #(
    parameter int STACK_DEPTH = 8,
    parameter int DATA_WORDS  = 256
) (
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic      [31:0]   hrdata,
    output logic               hreadyout,
    output logic               hresp,
    input  wire logic          ext_pin_event,
    input  wire logic          timer_overflow_event,
    input  wire logic          eeprom_done_event,
    input  wire logic [3:0]    upper_port_pins,
    output logic               irq_request,
    output logic      [12:0]   pc_value
);
    import cpc_pkg::*;

    localparam int SP_W = $clog2(STACK_DEPTH);

    // ========================================================================
    // elaboration checks
    // the stack pointer wraps by plain overflow, so depth must be a power of two
    if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_bad_depth
        $error("STACK_DEPTH must be a power of two, at least 2");
    end
    // data memory is reached through an eight-bit pointer
    if (DATA_WORDS < 16 || DATA_WORDS > 256) begin : g_bad_words
        $error("DATA_WORDS must lie between 16 and 256");
    end

    // ========================================================================
    // address decode, shared by direct and indirect paths
    function automatic cpc_sel_t decode_sel(input logic [8:0] idx);
        cpc_sel_t s;
        s = CPC_SEL_NONE;
        if (idx == `CPC_IDX_WINDOW) begin
            s = CPC_SEL_WINDOW;
        end else if (idx == `CPC_IDX_PC_LOW) begin
            s = CPC_SEL_PC_LOW;
        end else if (idx == `CPC_IDX_PTR) begin
            s = CPC_SEL_PTR;
        end else if (idx == `CPC_IDX_PC_HIGH) begin
            s = CPC_SEL_PC_HIGH;
        end else if (idx == `CPC_IDX_IRQ_CTRL) begin
            s = CPC_SEL_IRQ_CTRL;
        end else if (idx == `CPC_IDX_CMD) begin
            s = CPC_SEL_CMD;
        end else if (idx == `CPC_IDX_CORE_STAT) begin
            s = CPC_SEL_CORE_STAT;
        end else if (idx < 9'(DATA_WORDS)) begin
            s = CPC_SEL_MEM;
        end
        return s;
    endfunction : decode_sel

    // ========================================================================
    // interrupt request decision
    // fed with next values so the request follows a flag on the same edge
    function automatic logic irq_pending(input logic [7:0] c, input logic ee);
        logic any;
        any = (c[`CPC_EEPROM_DONE_IRQ_ENABLE_BIT] & ee) |
              (c[`CPC_TIMER_OVERFLOW_IRQ_ENABLE_BIT] & c[`CPC_TIMER_OVERFLOW_FLAG_BIT]) |
              (c[`CPC_EXT_PIN_IRQ_ENABLE_BIT] & c[`CPC_EXT_PIN_IRQ_FLAG_BIT]) |
              (c[`CPC_PORT_CHANGE_IRQ_ENABLE_BIT] & c[`CPC_PORT_CHANGE_FLAG_BIT]);
        return c[`CPC_GIE_BIT] & any;
    endfunction : irq_pending

    // ========================================================================
    // state
    logic [7:0]      mem [DATA_WORDS];
    logic [12:0]     stack [STACK_DEPTH];

    logic [31:0]     hrdata_ff,    nxt_hrdata;
    logic            hreadyout_ff, nxt_hreadyout;
    logic            hresp_ff;
    logic            a_valid_ff,   nxt_a_valid;
    logic            a_write_ff,   nxt_a_write;
    logic [8:0]      a_idx_ff,     nxt_a_idx;

    logic [7:0]      ctrl_ff,      nxt_ctrl;
    logic            ee_flag_ff,   nxt_ee_flag;
    logic            irq_ff,       nxt_irq;
    logic [12:0]     pc_ff,        nxt_pc;
    logic [4:0]      pc_high_ff,   nxt_pc_high;
    logic [7:0]      ptr_ff,       nxt_ptr;
    logic [SP_W-1:0] sp_ff,        nxt_sp;

    logic [3:0]      pins_s1_ff,   nxt_pins_s1;
    logic [3:0]      pins_s2_ff,   nxt_pins_s2;
    logic [3:0]      pins_s3_ff,   nxt_pins_s3;
    logic [3:0]      pins_stable_ff, nxt_pins_stable;
    logic            pins_settled_ff, nxt_pins_settled;

    // combinational helpers
    logic            accept;
    logic            wr_do;
    logic            rd_do;
    cpc_sel_t        bus_sel;
    cpc_sel_t        eff_sel;
    logic [8:0]      eff_idx;
    logic [7:0]      wbyte;
    logic [7:0]      rbyte;
    logic            port_change;
    cpc_op_t         op;
    logic            mem_we;
    logic [7:0]      mem_addr;
    logic            stk_we;
    logic [SP_W-1:0] stk_addr;

    // ========================================================================
    // upper port pins: three-stage synchroniser and change detect
    always_comb begin
        nxt_pins_s1      = upper_port_pins;
        nxt_pins_s2      = pins_s1_ff;
        nxt_pins_s3      = pins_s2_ff;
        nxt_pins_stable  = pins_stable_ff;
        nxt_pins_settled = pins_settled_ff;
        port_change      = 1'b0;
        // a change counts once stages two and three agree
        if (pins_s2_ff == pins_s3_ff) begin
            nxt_pins_stable  = pins_s3_ff;
            nxt_pins_settled = 1'b1;
            // the first settled value after reset is a baseline only
            port_change      = pins_settled_ff && (pins_s3_ff != pins_stable_ff);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pins_s1_ff      <= 4'h0;
            pins_s2_ff      <= 4'h0;
            pins_s3_ff      <= 4'h0;
            pins_stable_ff  <= 4'h0;
            pins_settled_ff <= 1'b0;
        end else begin
            pins_s1_ff      <= nxt_pins_s1;
            pins_s2_ff      <= nxt_pins_s2;
            pins_s3_ff      <= nxt_pins_s3;
            pins_stable_ff  <= nxt_pins_stable;
            pins_settled_ff <= nxt_pins_settled;
        end
    end

    // ========================================================================
    // next-state logic
    always_comb begin
        accept  = hsel & htrans[1] & hready;
        wr_do   = a_valid_ff & a_write_ff;
        rd_do   = a_valid_ff & ~a_write_ff;
        wbyte   = hwdata[7:0];
        bus_sel = decode_sel(a_idx_ff);
        // bank bit is unused here and reads as zero
        eff_idx = (bus_sel == CPC_SEL_WINDOW) ? {1'b0, ptr_ff} : a_idx_ff;
        eff_sel = decode_sel(eff_idx);

        // bus pipeline; reads take one wait state so a preceding write lands first
        nxt_a_valid   = accept;
        nxt_a_write   = accept ? hwrite : a_write_ff;
        nxt_a_idx     = accept ? haddr[10:2] : a_idx_ff;
        nxt_hreadyout = ~(accept & ~hwrite);
        nxt_hrdata    = hrdata_ff;

        // read mux
        rbyte = 8'h00;
        unique case (eff_sel)
            CPC_SEL_WINDOW:   rbyte = 8'h00;
            CPC_SEL_PC_LOW:   rbyte = pc_ff[7:0];
            CPC_SEL_PTR:      rbyte = ptr_ff;
            CPC_SEL_PC_HIGH:  rbyte = {3'h0, pc_high_ff};
            CPC_SEL_IRQ_CTRL: rbyte = ctrl_ff;
            CPC_SEL_MEM:      rbyte = mem[eff_idx[7:0]];
            CPC_SEL_CMD:      rbyte = 8'h00;
            CPC_SEL_CORE_STAT: rbyte = 8'h00;
            CPC_SEL_NONE:     rbyte = 8'h00;
        endcase
        if (rd_do) begin
            nxt_hreadyout = 1'b1;
            if (eff_sel == CPC_SEL_CORE_STAT) begin
                // stack pointer is deliberately absent from this word
                nxt_hrdata = 32'h0;
                nxt_hrdata[12:0] = pc_ff;
                nxt_hrdata[`CPC_STAT_IRQ_BIT] = irq_ff;
                nxt_hrdata[`CPC_STAT_EEF_BIT] = ee_flag_ff;
            end else begin
                nxt_hrdata = {24'h0, rbyte};
            end
        end
    end

    // ========================================================================
    // bus pipeline registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff    <= 32'h0;
            hreadyout_ff <= 1'b1;
            hresp_ff     <= 1'b0;
            a_valid_ff   <= 1'b0;
            a_write_ff   <= 1'b0;
            a_idx_ff     <= 9'h000;
        end else begin
            hrdata_ff    <= nxt_hrdata;
            hreadyout_ff <= nxt_hreadyout;
            // every answer is OKAY: no transfer is ever refused
            hresp_ff     <= 1'b0;
            a_valid_ff   <= nxt_a_valid;
            a_write_ff   <= nxt_a_write;
            a_idx_ff     <= nxt_a_idx;
        end
    end

    // ========================================================================
    // registers, program counter and return stack: next state
    always_comb begin
        // command decode: op in bits 14:12, branch target in bits 10:0
        op = CPC_OP_NOP;
        if (wr_do && eff_sel == CPC_SEL_CMD) begin
            op = cpc_op_t'(hwdata[`CPC_CMD_OP_HI:`CPC_CMD_OP_LO]);
        end

        // register writes
        nxt_ctrl    = ctrl_ff;
        nxt_ptr     = ptr_ff;
        nxt_pc_high = pc_high_ff;
        nxt_pc      = pc_ff;
        nxt_ee_flag = ee_flag_ff;
        mem_we      = 1'b0;
        mem_addr    = eff_idx[7:0];
        if (wr_do) begin
            unique case (eff_sel)
                CPC_SEL_WINDOW:   mem_we = 1'b0;
                // no carry from the low byte: computed jumps stay in their block
                CPC_SEL_PC_LOW:   nxt_pc = {2'b00, pc_high_ff[2:0], wbyte};
                CPC_SEL_PTR:      nxt_ptr = wbyte;
                CPC_SEL_PC_HIGH:  nxt_pc_high = wbyte[4:0];
                CPC_SEL_IRQ_CTRL: nxt_ctrl = wbyte;
                CPC_SEL_MEM:      mem_we = 1'b1;
                CPC_SEL_CORE_STAT: begin
                    if (hwdata[`CPC_STAT_EEF_BIT]) begin
                        nxt_ee_flag = 1'b0;
                    end
                end
                CPC_SEL_CMD:      mem_we = 1'b0;
                CPC_SEL_NONE:     mem_we = 1'b0;
            endcase
        end

        // program counter and return stack
        nxt_sp   = sp_ff;
        stk_we   = 1'b0;
        stk_addr = sp_ff;
        unique case (op)
            CPC_OP_NOP:  nxt_sp = sp_ff;
            CPC_OP_STEP: nxt_pc = pc_ff + 13'h0001;
            // page bits 4:3 of the holding register would extend this; not present here
            CPC_OP_GOTO: nxt_pc = {2'b00, hwdata[`CPC_CMD_TGT_HI:0]};
            CPC_OP_CALL: begin
                stk_we = 1'b1;
                nxt_sp = sp_ff + 1'b1;
                nxt_pc = {2'b00, hwdata[`CPC_CMD_TGT_HI:0]};
            end
            CPC_OP_RETURN, CPC_OP_RETLIT, CPC_OP_RETIRQ: begin
                // pointer simply wraps, so underflow replays old entries
                nxt_sp = sp_ff - 1'b1;
                nxt_pc = stack[nxt_sp];
                if (op == CPC_OP_RETIRQ) begin
                    nxt_ctrl[`CPC_GIE_BIT] = 1'b1;
                end
            end
            CPC_OP_IRQ_ACK: begin
                stk_we = 1'b1;
                nxt_sp = sp_ff + 1'b1;
                nxt_pc = `CPC_IRQ_VECTOR;
                nxt_ctrl[`CPC_GIE_BIT] = 1'b0;
            end
        endcase

        // events set flags after any software write, so a set beats a clear
        if (timer_overflow_event) begin
            nxt_ctrl[`CPC_TIMER_OVERFLOW_FLAG_BIT] = 1'b1;
        end
        if (ext_pin_event) begin
            nxt_ctrl[`CPC_EXT_PIN_IRQ_FLAG_BIT] = 1'b1;
        end
        if (port_change) begin
            nxt_ctrl[`CPC_PORT_CHANGE_FLAG_BIT] = 1'b1;
        end
        if (eeprom_done_event) begin
            nxt_ee_flag = 1'b1;
        end

        nxt_irq = irq_pending(nxt_ctrl, nxt_ee_flag);
    end

    // ========================================================================
    // control registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff         <= `CPC_IRQ_CTRL_RST;
            ee_flag_ff      <= 1'b0;
            irq_ff          <= 1'b0;
            pc_ff           <= `CPC_PC_RST;
            pc_high_ff      <= `CPC_PC_HIGH_RST;
            ptr_ff          <= `CPC_PTR_RST;
            sp_ff           <= '0;
        end else begin
            ctrl_ff         <= nxt_ctrl;
            ee_flag_ff      <= nxt_ee_flag;
            irq_ff          <= nxt_irq;
            pc_ff           <= nxt_pc;
            pc_high_ff      <= nxt_pc_high;
            ptr_ff          <= nxt_ptr;
            sp_ff           <= nxt_sp;
        end
    end

    // ========================================================================
    // storage arrays, not reset
    always_ff @(posedge hclk) begin
        if (mem_we) begin
            mem[mem_addr] <= wbyte;
        end
        if (stk_we) begin
            stack[stk_addr] <= pc_ff;
        end
    end

    assign hrdata      = hrdata_ff;
    assign hreadyout   = hreadyout_ff;
    assign hresp       = hresp_ff;
    assign irq_request = irq_ff;
    assign pc_value    = pc_ff;

endmodule : cpc_core

`default_nettype wire

// file: test/cpc_core_asserts.sv
// concurrent checks on the ports of the core program-counter block
`timescale 1ns/1ps
`default_nettype none
`include "cpc_params.svh"

module cpc_core_asserts (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        ext_pin_event,
    input wire logic        timer_overflow_event,
    input wire logic        eeprom_done_event,
    input wire logic [3:0]  upper_port_pins,
    input wire logic        irq_request,
    input wire logic [12:0] pc_value
);
    logic        wr_take;
    logic        rd_take;
    logic [8:0]  idx;
    logic [7:0]  wd_lo;
    logic [10:0] wd_tgt;
    assign idx     = haddr[10:2];
    assign wd_lo   = hwdata[7:0];
    assign wd_tgt  = hwdata[10:0];
    assign wr_take = hsel & htrans[1] & hready & hwrite;
    assign rd_take = hsel & htrans[1] & hready & ~hwrite;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // ========================================================================
    // bus timing and counter loading
    a_read_wait: assert property (rd_take |=> !hreadyout ##1 hreadyout)
        else $error("read data phase did not take exactly one wait state");
    a_write_ready: assert property (wr_take |=> hreadyout)
        else $error("write data phase stalled");
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("error response seen");
    a_pc_low_load: assert property (
        wr_take && idx == `CPC_IDX_PC_LOW ##1 1'b1
        |=> pc_value[7:0] == $past(wd_lo) && pc_value[12:11] == 2'b00)
        else $error("low byte write did not load the counter");
    a_goto_target: assert property (
        wr_take && idx == `CPC_IDX_CMD ##1 hwdata[14:13] == 2'b01
        |=> pc_value == {2'b00, $past(wd_tgt)})
        else $error("branch did not load its target");
    a_ack_vector: assert property (
        wr_take && idx == `CPC_IDX_CMD ##1 hwdata[14:12] == 3'h7
        |=> pc_value == `CPC_IRQ_VECTOR && !irq_request)
        else $error("acknowledge did not vector or left request up");
    // counter moves only by a command or register write
    a_pc_cause: assert property ($changed(pc_value) |-> $past(wr_take, 2))
        else $error("counter changed with no write");
    // events only set flags, so a fall needs software
    a_irq_drop: assert property ($fell(irq_request) |-> $past(wr_take, 2))
        else $error("request dropped with no write");
    a_reset_clear: assert property (
        $rose(hresetn) |-> pc_value == 13'h0000 && !irq_request)
        else $error("outputs not clear after reset");
endmodule : cpc_core_asserts

bind cpc_core cpc_core_asserts u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .ext_pin_event(ext_pin_event), .timer_overflow_event(timer_overflow_event),
    .eeprom_done_event(eeprom_done_event), .upper_port_pins(upper_port_pins),
    .irq_request(irq_request), .pc_value(pc_value));
`default_nettype wire

// file: test/core_pc_stack_irq_control_test.sv
// self-checking bench for the core program-counter, stack and interrupt block
`timescale 1ns/1ps
`default_nettype none
`include "cpc_params.svh"

module core_pc_stack_irq_control_test;
    import cpc_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0;
    logic        ev_ext = 1'b0, ev_tmr = 1'b0, ev_ee = 1'b0;
    logic        hreadyout, hresp, irq_request;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, sp;
    logic [3:0]  pins = 4'h0;
    logic [8:0]  a;
    logic [12:0] pc_value, pc, stk [8];
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, p, d, en, fl;
    logic [31:0] seed = 32'h0b290233, exp_q [$];
    int          n_fail = 0, num_checks = 0;

    always #10 hclk = ~hclk;

    cpc_core dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .ext_pin_event(ev_ext), .timer_overflow_event(ev_tmr),
        .eeprom_done_event(ev_ee), .upper_port_pins(pins),
        .irq_request(irq_request), .pc_value(pc_value));

    // ========================================================================
    // helpers
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xorshift

    function automatic logic [31:0] stat(input logic [12:0] v, input logic q, input logic e);
        return {14'h0, e, q, 3'h0, v};
    endfunction : stat

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic xfer(input logic wr, input logic [8:0] idx, input logic [31:0] wd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr  <= {21'h0, idx, 2'b00};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : xfer

    task automatic wr(input logic [8:0] idx, input logic [31:0] v);
        xfer(1'b1, idx, v);
    endtask : wr

    task automatic rd(input logic [8:0] idx, input logic [31:0] exp);
        exp_q.push_back(exp);
        xfer(1'b0, idx, 32'h0);
    endtask : rd

    task automatic cmd(input logic [2:0] op, input logic [10:0] t);
        wr(`CPC_IDX_CMD, {17'h0, op, 1'b0, t});
    endtask : cmd

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask : done

    task automatic summarize();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    // read data is taken at the edge where the data phase ends
    always @(posedge hclk) begin
        if (rd_dp && hreadyout) begin
            rd_dp = 1'b0;
            check(hrdata, exp_q.pop_front());
        end
        if (hsel && htrans[1] && hreadyout && !hwrite)
            rd_dp = 1'b1;
    end

    initial begin
        #200000;
        n_fail++;
        summarize();
    end

    // ========================================================================
    // scenarios
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`CPC_IDX_IRQ_CTRL, 32'h0);
        rd(`CPC_IDX_CORE_STAT, 32'h0);
        rd(`CPC_IDX_PC_HIGH, 32'h0);
        rd(`CPC_IDX_PTR, 32'h0);
        rd(9'h1ff, 32'h0);
        done("reset");
        @(posedge hclk);
        {ev_ext, ev_tmr, ev_ee} <= 3'b111;
        @(posedge hclk);
        {ev_ext, ev_tmr, ev_ee} <= 3'b000;
        rd(`CPC_IDX_IRQ_CTRL, 32'h06);
        rd(`CPC_IDX_CORE_STAT, stat(13'h0, 1'b0, 1'b1));
        p = xorshift();
        pins <= p[3:0] | 4'h1;
        repeat (8) @(posedge hclk);
        rd(`CPC_IDX_IRQ_CTRL, 32'h07);
        wr(`CPC_IDX_IRQ_CTRL, 32'h0);
        rd(`CPC_IDX_IRQ_CTRL, 32'h0);
        for (int i = 0; i < 3; i++) begin
            en = 32'h20 >> i;
            fl = 32'h04 >> i;
            wr(`CPC_IDX_IRQ_CTRL, 32'h80 | en | fl);
            rd(`CPC_IDX_CORE_STAT, stat(13'h0, 1'b1, 1'b1));
            check({31'h0, irq_request}, 32'h1);
            wr(`CPC_IDX_IRQ_CTRL, 32'h80 | en);
            rd(`CPC_IDX_CORE_STAT, stat(13'h0, 1'b0, 1'b1));
            check({31'h0, irq_request}, 32'h0);
            wr(`CPC_IDX_IRQ_CTRL, en | fl);
            rd(`CPC_IDX_CORE_STAT, stat(13'h0, 1'b0, 1'b1));
        end
        wr(`CPC_IDX_IRQ_CTRL, 32'hc0);
        rd(`CPC_IDX_CORE_STAT, stat(13'h0, 1'b1, 1'b1));
        wr(`CPC_IDX_CORE_STAT, 32'h20000);
        rd(`CPC_IDX_CORE_STAT, stat(13'h0, 1'b0, 1'b0));
        wr(`CPC_IDX_IRQ_CTRL, 32'h0);
        done("irq");
        wr(`CPC_IDX_PC_HIGH, 32'h1f);
        rd(`CPC_IDX_PC_HIGH, 32'h1f);
        p = xorshift();
        wr(`CPC_IDX_PC_LOW, p);
        pc = {2'b00, 3'b111, p[7:0]};
        rd(`CPC_IDX_CORE_STAT, stat(pc, 1'b0, 1'b0));
        rd(`CPC_IDX_PC_LOW, {24'h0, pc[7:0]});
        sp = 3'h0;
        // ten pushes wrap the eight slots; nine pops wrap back
        for (int i = 0; i < 11; i++) begin
            p = xorshift();
            if (i > 0) begin
                stk[sp] = pc;
                sp++;
            end
            pc = {2'b00, p[10:0]};
            cmd((i > 0) ? CPC_OP_CALL : CPC_OP_GOTO, p[10:0]);
        end
        rd(`CPC_IDX_CORE_STAT, stat(pc, 1'b0, 1'b0));
        for (int i = 0; i < 9; i++) begin
            sp--;
            pc = stk[sp];
            cmd(3'h4 + 3'(i % 2), 11'h0);
            rd(`CPC_IDX_CORE_STAT, stat(pc, 1'b0, 1'b0));
            check({19'h0, pc_value}, {19'h0, pc});
        end
        rd(`CPC_IDX_PC_HIGH, 32'h1f);
        wr(`CPC_IDX_IRQ_CTRL, 32'h80);
        stk[sp] = pc;
        sp++;
        cmd(CPC_OP_IRQ_ACK, 11'h0);
        rd(`CPC_IDX_CORE_STAT, stat(`CPC_IRQ_VECTOR, 1'b0, 1'b0));
        rd(`CPC_IDX_IRQ_CTRL, 32'h0);
        sp--;
        cmd(CPC_OP_RETIRQ, 11'h0);
        rd(`CPC_IDX_CORE_STAT, stat(stk[sp], 1'b0, 1'b0));
        rd(`CPC_IDX_IRQ_CTRL, 32'h80);
        done("stack");
        p = xorshift();
        a = 9'h020 + {2'b00, p[6:0]};
        d = {24'h0, p[15:8]};
        wr(a, d);
        wr(`CPC_IDX_PTR, {23'h0, 1'b1, a[7:0]});
        rd(`CPC_IDX_PTR, {24'h0, a[7:0]});
        rd(`CPC_IDX_WINDOW, d);
        wr(`CPC_IDX_WINDOW, ~d & 32'hff);
        rd(a, ~d & 32'hff);
        wr(`CPC_IDX_PTR, 32'h0b);
        wr(`CPC_IDX_IRQ_CTRL, 32'h28);
        rd(`CPC_IDX_WINDOW, 32'h28);
        wr(`CPC_IDX_PTR, 32'h0);
        wr(`CPC_IDX_WINDOW, 32'h55);
        rd(`CPC_IDX_WINDOW, 32'h0);
        rd(`CPC_IDX_PTR, 32'h0);
        rd(a, ~d & 32'hff);
        done("indirect");
        summarize();
    end
endmodule : core_pc_stack_irq_control_test
`default_nettype wire
